/* logic/clock_manager_phase_shift.sv */
// clock manager output stage: deskewed and quadrature clocks with
// fine phase offset, duty correction, lock and overflow status.
// assumes all inputs are synchronous to i_clk, which samples the
// source clock at 256 ticks per source period.
`timescale 1ns/1ps
`default_nettype none
`include "clock_manager_defs.svh"
module clock_manager_phase_shift
	import clock_manager_pkg::*;
#(
	parameter logic signed [8:0] PHASE_OFFSET = `OFFSET_RESET,
	parameter int unsigned TAP_SHIFT = 0,
	parameter logic [2:0] LOCK_PERIODS = `LOCK_PERIODS
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_source_clock_in,
	input wire logic i_feedback_clock_in,
	input wire logic i_phase_step_clock,
	input wire logic i_phase_step_direction,
	input wire logic i_phase_step_request,
	input wire phase_mode_t i_phase_adjust_mode,
	input wire logic i_high_freq_mode,
	input wire logic i_duty_cycle_correction,
	input wire logic i_startup_wait,
	output clock_set_t o_clocks,
	output logic o_lock,
	output logic o_phase_step_done,
	output logic o_config_release,
	output status_t o_status
);
	logic src_d_r, fb_d_r, ps_d_r, up_r;
	logic src_rise, fb_rise, ps_rise, period_ok;
	logic [7:0] tick_r, high_r, high_len_r, phase;
	logic fb_seen_r, lock_r, done_r, ovf_r;
	logic [2:0] lock_cnt_r;
	step_state_t state_r;
	logic signed [8:0] offset_r, applied_r, step_nxt, shift;
	logic sat_hit, variable;
	logic [6:0] lat_src_r;
	logic [1:0] lat_ps_r;

	// edge detection on the sampled clock-like inputs
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			src_d_r <= 1'b0;
			fb_d_r <= 1'b0;
			ps_d_r <= 1'b0;
			up_r <= 1'b0;
		end else begin
			src_d_r <= i_source_clock_in;
			fb_d_r <= i_feedback_clock_in;
			ps_d_r <= i_phase_step_clock;
			up_r <= 1'b1;
		end
	end
	assign src_rise = i_source_clock_in & ~src_d_r;
	assign fb_rise = i_feedback_clock_in & ~fb_d_r;
	assign ps_rise = i_phase_step_clock & ~ps_d_r;
	assign period_ok = src_rise && (tick_r == `PERIOD_LAST);

	// tick position within the source period, realigned on each rising edge
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			tick_r <= 8'h00;
		else if (src_rise)
			tick_r <= 8'h00;
		else
			tick_r <= tick_r + `TICK_ONE;
	end

	// high time of the source, used when duty correction is off
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			high_r <= 8'h00;
			high_len_r <= `HALF_TICKS;
		end else if (src_rise) begin
			high_len_r <= high_r;
			high_r <= `TICK_ONE;
		end else if (i_source_clock_in && high_r != `PERIOD_LAST) begin
			high_r <= high_r + `TICK_ONE;
		end
	end

	// feedback must show an edge every period; a new edge wins over
	// the per-period clear so it is never lost
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			fb_seen_r <= 1'b0;
		else if (fb_rise)
			fb_seen_r <= 1'b1;
		else if (src_rise)
			fb_seen_r <= 1'b0;
	end

	// lock after consecutive good periods; any bad period drops it
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lock_cnt_r <= 3'h0;
			lock_r <= 1'b0;
		end else if (src_rise) begin
			if (period_ok && fb_seen_r) begin
				if (lock_cnt_r != LOCK_PERIODS)
					lock_cnt_r <= lock_cnt_r + 3'h1;
				lock_r <= (lock_cnt_r == LOCK_PERIODS);
			end else begin
				lock_cnt_r <= 3'h0;
				lock_r <= 1'b0;
			end
		end
	end
	assign o_lock = lock_r;

	// configuration completion waits for lock when asked to
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_config_release <= 1'b0;
		else
			o_config_release <= ~i_startup_wait | lock_r;
	end

	// one numerator step in the requested direction
	assign variable = (i_phase_adjust_mode == MODE_VARIABLE);
	assign step_nxt = i_phase_step_direction ? offset_r + `OFFSET_ONE
		: offset_r - `OFFSET_ONE;
	assign sat_hit = i_phase_step_direction ? (offset_r == `OFFSET_MAX)
		: (offset_r == `OFFSET_MIN);

	// step handshake: request is taken on a step-clock edge in idle only, so once per step
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= ST_IDLE;
			offset_r <= PHASE_OFFSET;
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (ps_rise && i_phase_step_request && variable) begin
					if (!sat_hit)
						offset_r <= step_nxt;
					state_r <= ST_APPLY;
				end
			end
			ST_APPLY: begin
				if (src_rise)
					state_r <= ST_EDGE;
			end
			ST_EDGE: begin
				if (ps_rise)
					state_r <= ST_DONE;
			end
			default: begin
				if (ps_rise)
					state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// done stands from one step-clock edge to the next
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			done_r <= 1'b0;
		else if (ps_rise)
			done_r <= (state_r == ST_EDGE);
	end
	assign o_phase_step_done = done_r;

	// overflow is sticky until reset
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			ovf_r <= 1'b0;
		else if (state_r == ST_IDLE && ps_rise && i_phase_step_request
			&& variable && sat_hit)
			ovf_r <= 1'b1;
	end
	assign o_status = '{spare: 7'h00, overflow: ovf_r};

	// new offset only taken at the period boundary; an output pulse that spans it
	// is cut short or stretched by the change; zero sits at the middle of the line
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			applied_r <= PHASE_OFFSET;
		else if (src_rise) begin
			if (i_phase_adjust_mode == MODE_NONE)
				applied_r <= `OFFSET_RESET;
			else
				applied_r <= offset_r;
		end
	end

	// realised delay is quantised to the tap size
	assign shift = (applied_r >>> TAP_SHIFT) <<< TAP_SHIFT;
	assign phase = tick_r - shift[7:0];

	// level of a 1x clock at a given phase
	function automatic logic level_at(input logic [7:0] p,
		input logic dcc, input logic [7:0] hi_len);
		level_at = dcc ? (p < `HALF_TICKS) : (p < hi_len);
	endfunction : level_at

	// all four outputs share one phase, so one offset moves them all; quarter and three-quarter are held low in high-frequency mode
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_clocks <= '0;
		else begin
			o_clocks.deskewed <= level_at(phase,
				i_duty_cycle_correction, high_len_r);
			o_clocks.quarter <= ~i_high_freq_mode & level_at(
				phase - `QUARTER_TICKS, i_duty_cycle_correction,
				high_len_r);
			o_clocks.half <= level_at(phase - `HALF_TICKS,
				i_duty_cycle_correction, high_len_r);
			o_clocks.three_quarter <= ~i_high_freq_mode & level_at(
				phase - `THREE_Q_TICKS, i_duty_cycle_correction,
				high_len_r);
		end
	end

	// latency counters watched by the checks below; step-clock edges
	// only count once the source edge has passed, as a fast step clock
	// would otherwise run past its bound while waiting for the source
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lat_src_r <= 7'h00;
			lat_ps_r <= 2'h0;
		end else if (state_r == ST_IDLE) begin
			lat_src_r <= 7'h00;
			lat_ps_r <= 2'h0;
		end else begin
			if (src_rise && lat_src_r != 7'h7F)
				lat_src_r <= lat_src_r + 7'h01;
			if (ps_rise && state_r != ST_APPLY && lat_ps_r != 2'h3)
				lat_ps_r <= lat_ps_r + 2'h1;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_accept;
		state_r == ST_IDLE && ps_rise && i_phase_step_request && variable;
	endsequence
	sequence s_done_hold;
		done_r && !ps_rise;
	endsequence

	a_step_count: assert property (s_accept ##0 !sat_hit |=>
		offset_r == $past(step_nxt))
		else $error("step did not move the numerator by one");
	a_step_saturate: assert property (s_accept ##0 sat_hit |=>
		$stable(offset_r) && ovf_r)
		else $error("saturated step did not flag overflow");
	a_done_hold: assert property (s_done_hold |=> done_r)
		else $error("done dropped before next step-clock edge");
	a_done_drop: assert property (done_r && ps_rise |=> !done_r)
		else $error("done lasted beyond one step-clock period");
	a_step_latency: assert property (state_r != ST_IDLE |->
		lat_src_r <= `STEP_SRC_MAX && lat_ps_r < `STEP_PS_MAX)
		else $error("phase step took too long");
	a_offset_change: assert property ($changed(applied_r) |->
		$past(src_rise))
		else $error("offset changed away from the period boundary");
	a_none_zero: assert property (src_rise &&
		i_phase_adjust_mode == MODE_NONE |=> applied_r == `OFFSET_RESET)
		else $error("offset applied in mode none");
	a_offset_range: assert property (offset_r >= -`OFFSET_MAX &&
		offset_r <= `OFFSET_MAX)
		else $error("numerator out of range");
	a_quad_off: assert property (i_high_freq_mode |=>
		!o_clocks.quarter && !o_clocks.three_quarter)
		else $error("quadrature output active in high-frequency mode");
	a_half_inverse: assert property (up_r && i_duty_cycle_correction
		|=> o_clocks.half == !o_clocks.deskewed)
		else $error("half-phase output not opposite to deskewed");
	a_lock_cause: assert property ($rose(lock_r) |->
		$past(period_ok) && $past(lock_cnt_r) == LOCK_PERIODS)
		else $error("lock rose without enough good periods");
	a_config_hold: assert property (i_startup_wait && !lock_r |=>
		!o_config_release)
		else $error("configuration released before lock");

	// realignment, lock loss, release, done cause and offset tracking
	a_tick_realign: assert property (src_rise |=>
		tick_r == 8'h00)
		else $error("tick count not realigned on source edge");
	a_lock_loss: assert property (src_rise &&
		!(period_ok && fb_seen_r) |=> !lock_r)
		else $error("lock held across a bad period");
	a_release_free: assert property (!i_startup_wait |=>
		o_config_release)
		else $error("configuration held without startup wait");
	a_done_cause: assert property ($rose(done_r) |->
		$past(ps_rise) && $past(state_r) == ST_EDGE)
		else $error("done rose outside a finished step");
	a_ovf_sticky: assert property (ovf_r |=> ovf_r)
		else $error("overflow flag cleared without reset");
	a_offset_follow: assert property (src_rise &&
		i_phase_adjust_mode != MODE_NONE |=>
		applied_r == $past(offset_r))
		else $error("applied offset differs from the numerator");
	a_fixed_keep: assert property (
		i_phase_adjust_mode != MODE_VARIABLE |=> $stable(offset_r))
		else $error("numerator moved outside variable mode");
	a_quad_inverse: assert property (up_r && !i_high_freq_mode
		&& i_duty_cycle_correction |=>
		o_clocks.quarter == !o_clocks.three_quarter)
		else $error("quarter and three-quarter outputs not opposite");
endmodule : clock_manager_phase_shift
`default_nettype wire

/* logic/clock_manager_defs.svh */
// constants for the clock manager phase-shift output stage
// assumes a sampling clock of 50 MHz and 256 ticks per source period
`ifndef CLOCK_MANAGER_DEFS_SVH
`define CLOCK_MANAGER_DEFS_SVH
`define CLK_PERIOD_NS 20
`define PERIOD_LAST 8'hFF
`define QUARTER_TICKS 8'h40
`define HALF_TICKS 8'h80
`define THREE_Q_TICKS 8'hC0
`define TICK_ONE 8'h01
`define OFFSET_MAX 9'sh0FF
`define OFFSET_MIN 9'sh101
`define OFFSET_ONE 9'sh001
`define OFFSET_RESET 9'sh000
`define LOCK_PERIODS 3'h4
`define STEP_SRC_MAX 7'h64
`define STEP_PS_MAX 2'h3
`define STATUS_OVERFLOW_BIT 0
`endif

/* logic/clock_manager_pkg.sv */
// types for the clock manager phase-shift output stage
// assumes the constants header is included by the design file
`default_nettype none
package clock_manager_pkg;
	typedef enum logic [1:0] {
		MODE_NONE = 2'b00,
		MODE_FIXED = 2'b01,
		MODE_VARIABLE = 2'b10
	} phase_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_APPLY = 2'b01,
		ST_EDGE = 2'b10,
		ST_DONE = 2'b11
	} step_state_t;
	typedef struct packed {
		logic three_quarter;
		logic half;
		logic quarter;
		logic deskewed;
	} clock_set_t;
	typedef struct packed {
		logic [6:0] spare;
		logic overflow;
	} status_t;
endpackage : clock_manager_pkg
`default_nettype wire

/* sim/step_user_model.sv */
// user-side model of the phase-step handshake
// assumes i_clk samples everything; step clock is i_clk/8
`timescale 1ns/1ps
`default_nettype none
module step_user_model (
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic i_go,
	input wire logic i_dir,
	input wire logic i_done,
	output logic o_ps_clk,
	output logic o_ps_dir,
	output logic o_ps_req,
	output logic o_busy,
	output int o_wait,
	output int o_hi
);
	logic [2:0] div = 3'h0;
	logic sent = 1'b0;
	logic seen = 1'b0;
	initial begin
		{o_ps_clk, o_ps_dir, o_ps_req, o_busy} = 4'h0;
		o_wait = 0;
		o_hi = 0;
	end
	// step clock stands low while i_run is low, so fixed modes see zeros
	always @(posedge i_clk) begin
		#1;
		div = i_run ? div + 3'h1 : 3'h0;
		o_ps_clk = div[2];
		if (i_go && !o_busy) begin
			{o_busy, sent, seen} = 3'b100;
			o_wait = 0;
			o_hi = 0;
		end
		if (o_busy) o_wait++;
		if (i_done === 1'b1) o_hi++;
		// request spans exactly one step period, changed at the low half
		if (div == 3'h0 && o_ps_req) begin
			o_ps_req = 1'b0;
			o_ps_dir = !o_ps_dir; // released: show the inverse
		end else if (div == 3'h0 && o_busy && !sent) begin
			o_ps_req = 1'b1;
			o_ps_dir = i_dir;
			sent = 1'b1;
		end
		if (i_done === 1'b1) seen = 1'b1;
		if (seen && i_done === 1'b0) o_busy = 1'b0;
	end
endmodule : step_user_model
`default_nettype wire

/* sim/tb_clock_manager_phase_shift.sv */
// bench for the phase-shift output stage
// assumes the design samples a source clock of 256 ticks per period
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	miscompares++; $display("Error t=%0t got %h exp %h", $time, a, b); \
	end end
module tb_clock_manager_phase_shift;
	import clock_manager_pkg::*;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, hf = 1'b0, dcc = 1'b1, sw = 1'b1;
	logic run = 1'b0, go = 1'b0, dir = 1'b0, busy, ps_clk, ps_dir, ps_req;
	logic done, lock, rel;
	logic [7:0] tk = 8'h00, src_hi = 8'h80, p0, p, q;
	phase_mode_t mode = MODE_NONE;
	clock_set_t clks;
	status_t st;
	int miscompares = 0, num_checks = 0, num = 254, wt, hi, h, k;
	always #10 i_clk = !i_clk;
	// free tick count; source period fixed at 256 ticks
	always @(posedge i_clk) begin
		#2;
		tk <= tk + 8'h01;
	end
	clock_manager_phase_shift #(.PHASE_OFFSET(9'sh0FE)) dut (.i_clk,
		.i_sys_rst, .i_source_clock_in(tk < src_hi),
		.i_feedback_clock_in(clks.deskewed),
		.i_phase_step_clock(ps_clk), .i_phase_step_direction(ps_dir),
		.i_phase_step_request(ps_req), .i_phase_adjust_mode(mode),
		.i_high_freq_mode(hf), .i_duty_cycle_correction(dcc),
		.i_startup_wait(sw), .o_clocks(clks), .o_lock(lock),
		.o_phase_step_done(done), .o_config_release(rel), .o_status(st));
	step_user_model user (.i_clk, .i_run(run), .i_go(go), .i_dir(dir),
		.i_done(done), .o_ps_clk(ps_clk), .o_ps_dir(ps_dir),
		.o_ps_req(ps_req), .o_busy(busy), .o_wait(wt), .o_hi(hi));
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic tick(input int n = 1);
		repeat (n) @(posedge i_clk);
		#2;
	endtask : tick
	// bounded wait for one output bit to reach a level
	task automatic wait_lvl(input int s, input logic v);
		int i;
		for (i = 0; i < 600 && clks[s] !== v; i++) tick();
		if (i == 600) begin miscompares++; report_and_stop(); end
	endtask : wait_lvl
	// tick of the next rising edge of a bit, and its high time
	task automatic edge_of(input int s, output logic [7:0] r, output int n);
		wait_lvl(s, 1'b0);
		wait_lvl(s, 1'b1);
		r = tk;
		for (n = 0; n < 300 && clks[s] === 1'b1; n++) tick();
		if (n == 300) begin miscompares++; report_and_stop(); end
	endtask : edge_of
	task automatic wait_lock;
		int i;
		for (i = 0; i < 4000 && lock !== 1'b1; i++) tick();
		if (i == 4000) begin miscompares++; report_and_stop(); end
	endtask : wait_lock
	function automatic int sat(input int n, input logic up);
		n = up ? n + 1 : n - 1;
		return n > 255 ? 255 : (n < -255 ? -255 : n);
	endfunction : sat
	// one handshake step, then the edge must move by one tick, or stay put once the numerator is saturated at +-255
	task automatic step(input logic up);
		int i;
		dir = up;
		go = 1'b1;
		tick();
		go = 1'b0;
		for (i = 0; i < 30000 && (busy || i < 2); i++) tick();
		if (i == 30000) begin miscompares++; report_and_stop(); end
		num = sat(num, up);
		`CHK(wt <= 100 * 256 + 5 * 8, 1'b1)
		`CHK(hi, 8)
		tick(512);
		edge_of(0, p, h);
		`CHK(p, 8'(p0 + num))
	endtask : step
	initial begin
		void'($urandom(88));
		tick(20);
		i_sys_rst = 1'b0;
		tick(2);
		`CHK(rel, 1'b0)
		wait_lock();
		tick(2);
		`CHK(rel, 1'b1)
		`CHK(st, 8'h00)
		edge_of(0, p0, h);
		`CHK(h, 128)
		for (k = 1; k < 4; k++) begin
			edge_of(k, q, h);
			`CHK(8'(q - p0), 8'(k * 64))
		end
		mode = MODE_FIXED;
		tick(600);
		edge_of(0, p, h);
		`CHK(p, 8'(p0 + 254))
		edge_of(1, q, h);
		`CHK(8'(q - p), 8'h40)
		mode = MODE_VARIABLE;
		run = 1'b1;
		step(1'b1);
		`CHK(st.overflow, 1'b0)
		step(1'b1);
		`CHK(st.overflow, 1'b1)
		repeat (6) step(1'($urandom_range(1, 0)));
		dcc = 1'b0;
		src_hi = 8'h64;
		tick(600);
		edge_of(0, p, h);
		`CHK(h, 100)
		dcc = 1'b1;
		src_hi = 8'h80;
		hf = 1'b1;
		tick(300);
		for (k = 0; k < 300; k++) begin
			tick();
			`CHK(clks.quarter | clks.three_quarter, 1'b0)
		end
		hf = 1'b0;
		run = 1'b0;
		sw = 1'b0;
		i_sys_rst = 1'b1;
		tick();
		`CHK(lock, 1'b0)
		`CHK(rel, 1'b0)
		tick(3);
		i_sys_rst = 1'b0;
		tick(2);
		`CHK(rel, 1'b1)
		wait_lock();
		`CHK(st, 8'h00)
		tick(600);
		edge_of(0, p, h);
		`CHK(p, 8'(p0 + 254))
		mode = MODE_NONE;
		tick(600);
		edge_of(0, p, h);
		`CHK(p, p0)
		report_and_stop();
	end
endmodule : tb_clock_manager_phase_shift
`default_nettype wire
